// [dv/cgscp_ctl.sv]
// System controller model for the serial control port
`timescale 1ns/1ns
module cgscp_ctl (
   // Clock
   input wire logic clock,
   // Serial pins
   output logic sclk,
   output logic chip_select_n,
   output logic port_abort,
   output logic d_out,
   input wire logic sdio,
   input wire logic serial_separate_output
);
   logic lsb = 1'b0;
   logic split = 1'b0;
   logic abort_cut = 1'b0;
   logic keep_cs = 1'b0;
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      port_abort = 1'b0;
      d_out = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clock);
   endtask : w
   // Half periods of four clocks give 320 ns on the serial clock
   task automatic xfer(input logic [7:0] ins, input logic [47:0] wd, input int nb,
      input int cut, output logic [47:0] rd);
      int i;
      rd = '0;
      chip_select_n = 1'b0;
      w(4);
      for (int k = 0; k < 8 + nb; k++) begin
         if (k == cut && abort_cut) begin
            port_abort = 1'b1;
            w(8);
            port_abort = 1'b0;
            w(4);
            chip_select_n = 1'b1;
            w(8);
            return;
         end
         if (k == cut) begin
            chip_select_n = 1'b1;
            repeat (4) begin
               w(4);
               sclk = ~sclk;
            end
            chip_select_n = 1'b0;
            w(4);
         end
         i = (k < 8) ? (lsb ? k : 7 - k) : (lsb ? k - 8 : nb - 1 - (k - 8));
         // A released line toggles so stale data never reads as valid
         d_out = (k >= 8 && ins[7]) ? ~d_out : ((k < 8) ? ins[i] : wd[i]);
         w(4);
         // Read bit is taken at the rise; the device may float the line right after the last one
         if (k >= 8) rd[i] = split ? serial_separate_output : sdio;
         sclk = 1'b1;
         w(4);
         sclk = 1'b0;
      end
      w(4);
      chip_select_n = ~keep_cs;
      w(8);
   endtask : xfer
endmodule : cgscp_ctl

// [dv/cgscp_monitor.sv]
// Protocol checker for the serial control port
`timescale 1ns/1ns
module cgscp_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pins
   input wire logic chip_select_n,
   input wire logic port_abort,
   input wire logic serial_shared_data_line_oe,
   input wire logic serial_separate_output_oe,
   // Registers and status
   input wire logic [31:0] control_function_word_one,
   input wire logic [31:0] control_function_word_two,
   input wire logic [23:0] rise_delta_word,
   input wire logic [23:0] fall_delta_word,
   input wire logic [47:0] tuning_word,
   input wire logic bit_order_select,
   input wire logic shared_line_input_only,
   input wire logic transfer_busy,
   input wire logic write_done
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic [159:0] words;
   assign words = {control_function_word_one, control_function_word_two, rise_delta_word,
      fall_delta_word, tuning_word};
   // Six cycles leave room for the pin synchronisers
   sequence s_cs_idle; chip_select_n [*6]; endsequence
   sequence s_abort_held; port_abort [*6]; endsequence
   a_cs_floats: assert property (s_cs_idle |-> !serial_shared_data_line_oe
      && !serial_separate_output_oe) else $error("output driven while deselected");
   a_abort_idles: assert property (s_abort_held |-> !transfer_busy)
      else $error("busy while abort held");
   a_abort_keeps: assert property (s_abort_held |=> $stable(words) && !write_done)
      else $error("register changed during abort");
   a_commit_pulse: assert property (write_done |=> !write_done)
      else $error("commit pulse too long");
   a_words_commit: assert property ($changed(words) |-> write_done || $past(write_done))
      else $error("register changed without commit");
   a_shared_mode: assert property (!shared_line_input_only |-> !serial_separate_output_oe)
      else $error("separate output driven in shared mode");
   a_split_mode: assert property (shared_line_input_only |-> !serial_shared_data_line_oe)
      else $error("shared line driven in split mode");
   a_mode_mirror: assert property ($stable(control_function_word_one) [*2] |->
      bit_order_select == control_function_word_one[15]
      && shared_line_input_only == control_function_word_one[7]) else $error("mode bits stale");
endmodule : cgscp_monitor
bind cgscp_port cgscp_monitor mon (.clock, .rst, .chip_select_n, .port_abort,
   .serial_shared_data_line_oe, .serial_separate_output_oe, .control_function_word_one,
   .control_function_word_two, .rise_delta_word, .fall_delta_word, .tuning_word,
   .bit_order_select, .shared_line_input_only, .transfer_busy, .write_done);

// [dv/cgscp_port_tb.sv]
// Testbench for the serial control port
`timescale 1ns/1ns
module cgscp_port_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, abort, d, sd_out, sd_oe, so_out, so_oe, bos, slio, busy, wdone;
   logic sdio, serial_separate_output;
   logic [31:0] w1, w2;
   logic [23:0] rw, fw;
   logic [47:0] tw, r;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   assign sdio = sd_oe ? sd_out : d;
   assign serial_separate_output = so_oe ? so_out : ~so_out;
   initial forever #20 clock = ~clock;
   cgscp_port DUT (.clock(clock), .rst(rst), .sclk(sclk), .chip_select_n(cs_n),
      .port_abort(abort), .serial_shared_data_line_in(sdio), .serial_shared_data_line_out(sd_out),
      .serial_shared_data_line_oe(sd_oe), .serial_separate_output_out(so_out),
      .serial_separate_output_oe(so_oe), .control_function_word_one(w1),
      .control_function_word_two(w2), .rise_delta_word(rw), .fall_delta_word(fw),
      .tuning_word(tw), .bit_order_select(bos), .shared_line_input_only(slio),
      .transfer_busy(busy), .write_done(wdone));
   cgscp_ctl u (.clock(clock), .sclk(sclk), .chip_select_n(cs_n), .port_abort(abort),
      .d_out(d), .sdio(sdio), .serial_separate_output(serial_separate_output));
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      repeat (16) @(negedge clock);
      rst = 1'b0;
      repeat (4) @(negedge clock);
      chk({16'h0000, w2}, cgscp_pkg::RST_CFW_TWO);
      chk({44'h0, bos, slio, sd_oe, so_oe}, 48'h0);
      u.xfer(8'h61, 48'hA5C30F12, 32, -1, r);
      chk({16'h0000, w2}, 48'hA5C30F12);
      u.xfer(8'h81, 48'h0, 32, -1, r);
      chk(r, 48'hA5C30F12);
      u.xfer(8'h04, 48'h123456789ABC, 48, 20, r);
      chk(tw, 48'h123456789ABC);
      u.xfer(8'h84, 48'h0, 48, -1, r);
      chk(r, 48'h123456789ABC);
      u.abort_cut = 1'b1;
      u.xfer(8'h02, 48'hFFEEDD, 24, 14, r);
      chk({24'h0, rw}, 48'h0);
      u.abort_cut = 1'b0;
      u.keep_cs = 1'b1;
      u.xfer(8'h03, 48'h5A5A5A, 24, -1, r);
      chk({24'h0, fw}, 48'h5A5A5A);
      u.xfer(8'h1F, 48'hFF, 8, -1, r);
      chk({16'h0000, w2}, 48'hA5C30F12);
      u.keep_cs = 1'b0;
      u.xfer(8'h00, 48'h8080, 32, -1, r);
      u.lsb = 1'b1;
      u.split = 1'b1;
      chk({46'h0, bos, slio}, 48'h3);
      u.xfer(8'h02, 48'hC1A2B3, 24, -1, r);
      chk({24'h0, rw}, 48'hC1A2B3);
      u.xfer(8'h82, 48'h0, 24, -1, r);
      chk(r, 48'hC1A2B3);
      give_verdict();
   end
endmodule : cgscp_port_tb

// [src/cgscp_pkg.sv]
// Constants, register layout and phase type for the clock generator serial control port
//
// Contract
// - Instruction byte takes first eight rising edges
// - Instruction gives target register and direction
// - Data phase length equals addressed register width
// - After a transfer, next eight edges are instruction
// - Incoming data sampled on serial clock rise
// - Outgoing data launched on serial clock fall
// - Instruction bit 7 high reads, low writes
// - Instruction bits 6 and 5 are ignored
// - Instruction bits 4 to 0 select register
// - Chip select high floats both data outputs
// - Chip select high suspends, low resumes transfer
// - Shared line always takes writes; bit selects reads
// - Separate output floats in shared line mode
// - Port abort idles port, keeps register contents
// - After abort, new transfer starts with instruction
// - Bit order select: low MSB first, high LSB
// - Instruction byte follows the selected bit order
// - Data phase bits follow the selected bit order
package cgscp_pkg;

   // ----------------------------------------
   // Register selects and widths
   // ----------------------------------------
   localparam logic [4:0] SEL_CFW_ONE = 5'h00;
   localparam logic [4:0] SEL_CFW_TWO = 5'h01;
   localparam logic [4:0] SEL_RISE_DELTA = 5'h02;
   localparam logic [4:0] SEL_FALL_DELTA = 5'h03;
   localparam logic [4:0] SEL_TUNING = 5'h04;
   localparam int NUM_REGS = 5;
   localparam int REG_W = 48;
   localparam logic [2:0] BYTES_CFW_ONE = 3'h4;
   localparam logic [2:0] BYTES_CFW_TWO = 3'h4;
   localparam logic [2:0] BYTES_DELTA = 3'h3;
   localparam logic [2:0] BYTES_TUNING = 3'h6;
   localparam logic [2:0] BYTES_UNMAPPED = 3'h1;
   localparam logic [5:0] INSTR_BITS = 6'h08;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [47:0] RST_CFW_ONE = 48'h0000_0000_0000;
   localparam logic [47:0] RST_CFW_TWO = 48'h0000_0078_0007;
   localparam logic [47:0] RST_DELTA = 48'h0000_0000_0000;
   localparam logic [47:0] RST_TUNING = 48'h0000_0000_0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int POS_DIRECTION = 7;
   localparam int POS_BIT_ORDER = 15;
   localparam int POS_INPUT_ONLY = 7;

   typedef enum logic {
      PH_INSTR,
      PH_DATA
   } cgscp_phase_e;

   function automatic logic [2:0] cgscp_reg_bytes(input logic [4:0] sel);
      logic [2:0] n;
      n = BYTES_UNMAPPED;
      unique case (sel)
         SEL_CFW_ONE: n = BYTES_CFW_ONE;
         SEL_CFW_TWO: n = BYTES_CFW_TWO;
         SEL_RISE_DELTA: n = BYTES_DELTA;
         SEL_FALL_DELTA: n = BYTES_DELTA;
         SEL_TUNING: n = BYTES_TUNING;
         default: n = BYTES_UNMAPPED;
      endcase
      return n;
   endfunction : cgscp_reg_bytes

endpackage : cgscp_pkg

// [src/cgscp_port.sv]
// Serial control port of the clock generator, device side
`timescale 1ns/1ns
module cgscp_port (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Serial pins from the controller
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic port_abort,
   // Shared data line
   input wire logic serial_shared_data_line_in,
   output logic serial_shared_data_line_out,
   output logic serial_shared_data_line_oe,
   // Separate serial output
   output logic serial_separate_output_out,
   output logic serial_separate_output_oe,
   // Register contents toward the core
   output logic [31:0] control_function_word_one,
   output logic [31:0] control_function_word_two,
   output logic [23:0] rise_delta_word,
   output logic [23:0] fall_delta_word,
   output logic [47:0] tuning_word,
   // Status
   output logic bit_order_select,
   output logic shared_line_input_only,
   output logic transfer_busy,
   output logic write_done
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] sclk_sync;
      logic sclk_prev;
      logic [1:0] cs_sync;
      logic [1:0] din_sync;
      logic [1:0] abort_sync;
      cgscp_pkg::cgscp_phase_e phase;
      logic [5:0] cnt;
      logic [5:0] tx_cnt;
      logic [5:0] len;
      logic read;
      logic [4:0] sel;
      logic [7:0] instr;
      logic [47:0] shift;
      logic dout;
      logic wr_pulse;
      logic [cgscp_pkg::NUM_REGS-1:0][47:0] regs;
   } cgscp_state_s;

   cgscp_state_s st;
   cgscp_state_s next_st;

   // ----------------------------------------
   // Edge detection and helpers
   // ----------------------------------------
   logic sclk_rise;
   logic sclk_fall;
   logic selected;
   logic aborting;
   logic lsb_first;
   logic input_only;
   logic din;
   logic [5:0] rx_pos;
   logic [5:0] tx_pos;
   logic [7:0] instr_now;
   logic [5:0] data_bits;
   logic [4:0] sel_now;
   logic drive_read;

   // Both edges come from the synchronised copy, so sclk may be slow or stop anywhere
   assign sclk_rise = st.sclk_sync[1] & ~st.sclk_prev;
   assign sclk_fall = ~st.sclk_sync[1] & st.sclk_prev;
   assign selected = ~st.cs_sync[1];
   assign aborting = st.abort_sync[1];
   assign din = st.din_sync[1];
   assign lsb_first = st.regs[cgscp_pkg::SEL_CFW_ONE][cgscp_pkg::POS_BIT_ORDER];
   assign input_only = st.regs[cgscp_pkg::SEL_CFW_ONE][cgscp_pkg::POS_INPUT_ONLY];

   // Position of the current bit inside the word being moved
   assign rx_pos = lsb_first ? st.cnt : 6'(st.len - st.cnt - 6'h01);
   assign tx_pos = lsb_first ? st.tx_cnt : 6'(st.len - st.tx_cnt - 6'h01);

   always_comb begin
      instr_now = st.instr;
      instr_now[rx_pos[2:0]] = din;
   end

   assign sel_now = instr_now[4:0];
   assign data_bits = {cgscp_pkg::cgscp_reg_bytes(sel_now), 3'h0};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.sclk_sync = {st.sclk_sync[0], sclk};
      next_st.sclk_prev = st.sclk_sync[1];
      next_st.cs_sync = {st.cs_sync[0], chip_select_n};
      next_st.din_sync = {st.din_sync[0], serial_shared_data_line_in};
      next_st.abort_sync = {st.abort_sync[0], port_abort};
      next_st.wr_pulse = 1'b0;
      if (aborting) begin
         // Only the port is cleared; stored words stay as they are
         next_st.phase = cgscp_pkg::PH_INSTR;
         next_st.cnt = 6'h00;
         next_st.tx_cnt = 6'h00;
         next_st.len = cgscp_pkg::INSTR_BITS;
         next_st.instr = 8'h00;
         next_st.read = 1'b0;
      end else if (selected) begin
         if (sclk_rise) begin
            unique case (st.phase)
               cgscp_pkg::PH_INSTR: begin
                  next_st.instr = instr_now;
                  next_st.cnt = 6'(st.cnt + 6'h01);
                  if (st.cnt == 6'(cgscp_pkg::INSTR_BITS - 6'h01)) begin
                     next_st.phase = cgscp_pkg::PH_DATA;
                     next_st.cnt = 6'h00;
                     next_st.tx_cnt = 6'h00;
                     next_st.len = data_bits;
                     next_st.read = instr_now[cgscp_pkg::POS_DIRECTION];
                     next_st.sel = sel_now;
                     next_st.shift = 48'h0000_0000_0000;
                     if (instr_now[cgscp_pkg::POS_DIRECTION] &&
                         (sel_now < 5'(cgscp_pkg::NUM_REGS))) begin
                        next_st.shift = st.regs[sel_now[2:0]];
                     end
                  end
               end
               cgscp_pkg::PH_DATA: begin
                  if (!st.read) begin
                     next_st.shift[rx_pos] = din;
                  end
                  next_st.cnt = 6'(st.cnt + 6'h01);
                  if (st.cnt == 6'(st.len - 6'h01)) begin
                     // Transfer complete; the next edge starts a fresh instruction
                     next_st.phase = cgscp_pkg::PH_INSTR;
                     next_st.cnt = 6'h00;
                     next_st.len = cgscp_pkg::INSTR_BITS;
                     next_st.instr = 8'h00;
                     if (!st.read && (st.sel < 5'(cgscp_pkg::NUM_REGS))) begin
                        // Commit only whole words, never a partial write
                        next_st.regs[st.sel[2:0]] = next_st.shift;
                        next_st.wr_pulse = 1'b1;
                     end
                  end
               end
            endcase
         end else if (sclk_fall && (st.phase == cgscp_pkg::PH_DATA) && st.read) begin
            if (st.tx_cnt < st.len) begin
               next_st.dout = st.shift[tx_pos];
               next_st.tx_cnt = 6'(st.tx_cnt + 6'h01);
            end
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         st.sclk_sync <= 2'h0;
         st.sclk_prev <= 1'b0;
         st.cs_sync <= 2'h3;
         st.din_sync <= 2'h0;
         st.abort_sync <= 2'h0;
         st.phase <= cgscp_pkg::PH_INSTR;
         st.cnt <= 6'h00;
         st.tx_cnt <= 6'h00;
         st.len <= cgscp_pkg::INSTR_BITS;
         st.read <= 1'b0;
         st.sel <= 5'h00;
         st.instr <= 8'h00;
         st.shift <= 48'h0000_0000_0000;
         st.dout <= 1'b0;
         st.wr_pulse <= 1'b0;
         st.regs[cgscp_pkg::SEL_CFW_ONE] <= cgscp_pkg::RST_CFW_ONE;
         st.regs[cgscp_pkg::SEL_CFW_TWO] <= cgscp_pkg::RST_CFW_TWO;
         st.regs[cgscp_pkg::SEL_RISE_DELTA] <= cgscp_pkg::RST_DELTA;
         st.regs[cgscp_pkg::SEL_FALL_DELTA] <= cgscp_pkg::RST_DELTA;
         st.regs[cgscp_pkg::SEL_TUNING] <= cgscp_pkg::RST_TUNING;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // Selected and in a read data phase; deselect floats both lines at once
   assign drive_read = selected & ~aborting & st.read & (st.phase == cgscp_pkg::PH_DATA);
   assign serial_shared_data_line_out = st.dout;
   assign serial_shared_data_line_oe = drive_read & ~input_only;
   assign serial_separate_output_out = st.dout;
   assign serial_separate_output_oe = drive_read & input_only;

   // ----------------------------------------
   // Register and status outputs
   // ----------------------------------------
   assign control_function_word_one = st.regs[cgscp_pkg::SEL_CFW_ONE][31:0];
   assign control_function_word_two = st.regs[cgscp_pkg::SEL_CFW_TWO][31:0];
   assign rise_delta_word = st.regs[cgscp_pkg::SEL_RISE_DELTA][23:0];
   assign fall_delta_word = st.regs[cgscp_pkg::SEL_FALL_DELTA][23:0];
   assign tuning_word = st.regs[cgscp_pkg::SEL_TUNING];
   assign bit_order_select = lsb_first;
   assign shared_line_input_only = input_only;
   assign transfer_busy = (st.phase == cgscp_pkg::PH_DATA) | (st.cnt != 6'h00);
   assign write_done = st.wr_pulse;

endmodule : cgscp_port
